// File: rtl/mls_stall_top.sv
// Load measurement and stall stop controller with Avalon-MM registers
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`include "mls_defs.svh"
module mls_stall_top #(
	parameter int VEL_W = 24,   // Width of actual velocity
	parameter int ZW_W  = 16    // Width of zero wait count
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [7:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             fullstep_pulse,
	input  wire logic [9:0]       raw_load,
	input  wire logic [VEL_W-1:0] actual_velocity,
	output logic                  ramp_halt,
	output logic                  irq
);

	// ==========================================================
	// Elaboration checks
	if (VEL_W < 2 || VEL_W > 31) begin : g_bad_vel
		$error("mls_stall_top: VEL_W out of range");
	end
	if (ZW_W < 1 || ZW_W > 32) begin : g_bad_zw
		$error("mls_stall_top: ZW_W out of range");
	end

	// ==========================================================
	// Declarations
	mls_load_if ld ();                                    // Link to filter

	logic                     stop_en_reg, stop_en_next;  // Stop-on-stall
	logic [6:0]               sgt_reg, sgt_next;          // Stall threshold
	logic                     filt_reg, filt_next;        // Filter enable
	logic [VEL_W-2:0]         vlow_reg, vlow_next;        // Lower velocity limit
	logic [ZW_W-1:0]          zw_reg, zw_next;            // Zero wait length
	logic [1:0]               imask_reg, imask_next;      // Interrupt mask
	logic [1:0]               istat_reg, istat_next;      // Sticky events
	logic                     wait_reg, wait_next;        // Waitrequest
	logic [31:0]              rdata_reg, rdata_next;      // Read data
	logic                     irq_reg, irq_next;          // Interrupt line
	mls_pkg::mls_stall_state_t st_reg, st_next;           // Stop sequence
	logic [ZW_W-1:0]          zcnt_reg, zcnt_next;        // Zero wait count
	logic                     halt_reg, halt_next;        // Ramp halt output
	logic                     vabove_reg, vabove_next;    // Above limit

	logic                     wr_acc, rd_acc;   // Access at acknowledge edge
	logic                     rstat_clr;        // Ramp status read-clear
	logic                     stall_hit;        // Qualified stall this cycle
	logic [VEL_W-2:0]         vel_mag;          // Velocity magnitude
	logic [VEL_W-1:0]         vel_neg;          // Negated velocity, full width
	logic signed [11:0]       comp;             // Threshold-compensated load

	// Address match used by read and write decoding
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ==========================================================
	// Load compensation and filter
	always_comb begin
		// Positive threshold raises the reading, so more torque is needed
		comp = $signed({2'b00, raw_load})
			+ ($signed({{5{sgt_reg[6]}}, sgt_reg}) <<< `MLS_SGT_SHIFT);
		// Clamp into the reported range; heavy load settles at zero
		if (comp < 0) begin
			ld.sample = '0;
		end else if (comp > $signed({2'b00, `MLS_LOAD_MAX})) begin
			ld.sample = `MLS_LOAD_MAX;
		end else begin
			ld.sample = comp[9:0];
		end
	end

	assign ld.sample_valid = fullstep_pulse;
	assign ld.filt_en      = filt_reg;

	mls_load_filter #(
		.FILT_LOG2 (`MLS_FILT_LOG2)
	) u_filter (
		.clk  (clk),
		.nrst (nrst),
		.ld   (ld)
	);

	// ==========================================================
	// Bus slave and register file
	// One wait state: waitrequest drops for one cycle per request
	always_comb begin
		wr_acc     = avs_write && !wait_reg;
		rd_acc     = avs_read && !wait_reg;
		rstat_clr  = rd_acc && hit(avs_address, `MLS_OFF_RSTAT);
		wait_next  = !((avs_read || avs_write) && wait_reg);
		stop_en_next = stop_en_reg;
		sgt_next   = sgt_reg;
		filt_next  = filt_reg;
		vlow_next  = vlow_reg;
		zw_next    = zw_reg;
		imask_next = imask_reg;
		rdata_next = rdata_reg;
		// Writes land at the edge where waitrequest is seen low
		if (wr_acc) begin
			if (hit(avs_address, `MLS_OFF_SWMODE)) begin
				stop_en_next = avs_writedata[`MLS_SW_STOP_BIT];
			end else if (hit(avs_address, `MLS_OFF_LOADCFG)) begin
				sgt_next  = avs_writedata[`MLS_CFG_SGT_LSB +: `MLS_CFG_SGT_W];
				filt_next = avs_writedata[`MLS_CFG_FILT_BIT];
			end else if (hit(avs_address, `MLS_OFF_VLOW)) begin
				vlow_next = avs_writedata[VEL_W-2:0];
			end else if (hit(avs_address, `MLS_OFF_ZWAIT)) begin
				zw_next = avs_writedata[ZW_W-1:0];
			end else if (hit(avs_address, `MLS_OFF_IMASK)) begin
				imask_next = avs_writedata[1:0];
			end
		end
		// Read data prepared while waitrequest is high, stands at acknowledge
		if ((avs_read) && wait_reg) begin
			rdata_next = 32'h0000_0000;
			if (hit(avs_address, `MLS_OFF_SWMODE)) begin
				rdata_next[`MLS_SW_STOP_BIT] = stop_en_reg;
			end else if (hit(avs_address, `MLS_OFF_LOADCFG)) begin
				rdata_next[`MLS_CFG_SGT_LSB +: `MLS_CFG_SGT_W] = sgt_reg;
				rdata_next[`MLS_CFG_FILT_BIT] = filt_reg;
			end else if (hit(avs_address, `MLS_OFF_VLOW)) begin
				rdata_next[VEL_W-2:0] = vlow_reg;
			end else if (hit(avs_address, `MLS_OFF_ZWAIT)) begin
				rdata_next[ZW_W-1:0] = zw_reg;
			end else if (hit(avs_address, `MLS_OFF_RSTAT)) begin
				rdata_next[`MLS_RSTAT_EVT_BIT] = (st_reg == mls_pkg::mls_st_halt);
			end else if (hit(avs_address, `MLS_OFF_DSTAT)) begin
				rdata_next[9:0] = ld.result;
				rdata_next[`MLS_DSTAT_STALL_BIT] = (st_reg == mls_pkg::mls_st_halt);
			end else if (hit(avs_address, `MLS_OFF_ISTAT)) begin
				rdata_next[1:0] = istat_reg;
			end else if (hit(avs_address, `MLS_OFF_IMASK)) begin
				rdata_next[1:0] = imask_reg;
			end
		end
	end

	// Bus registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_reg    <= 1'b1;
			rdata_reg   <= 32'h0000_0000;
			stop_en_reg <= `MLS_RST_SWMODE;
			sgt_reg     <= `MLS_RST_SGT;
			filt_reg    <= `MLS_RST_FILT;
			vlow_reg    <= '0;
			zw_reg      <= '0;
			imask_reg   <= `MLS_RST_IMASK;
		end else begin
			wait_reg    <= wait_next;
			rdata_reg   <= rdata_next;
			stop_en_reg <= stop_en_next;
			sgt_reg     <= sgt_next;
			filt_reg    <= filt_next;
			vlow_reg    <= vlow_next;
			zw_reg      <= zw_next;
			imask_reg   <= imask_next;
		end
	end

	// ==========================================================
	// Stall stop sequence and interrupts
	always_comb begin
		// Magnitude of the signed velocity; sign bit dropped
		// Negation kept at full width; a cast cannot be part-selected
		vel_neg = -actual_velocity;
		if (actual_velocity[VEL_W-1]) begin
			vel_mag = vel_neg[VEL_W-2:0];
		end else begin
			vel_mag = actual_velocity[VEL_W-2:0];
		end
		// Low speeds give unreliable readings, so they are ignored
		vabove_next = (vel_mag > vlow_reg);
		// A zero reading while enabled and fast enough is a stall
		stall_hit = ld.result_valid && (ld.result == 10'h000)
			&& vabove_reg && stop_en_reg;
		st_next   = st_reg;
		zcnt_next = zcnt_reg;
		case (st_reg)
			mls_pkg::mls_st_run: begin
				if (stall_hit) begin
					st_next = mls_pkg::mls_st_halt;
				end
			end
			mls_pkg::mls_st_halt: begin
				if (!stop_en_reg) begin
					// Disabling the stop releases at once
					st_next = mls_pkg::mls_st_run;
				end else if (rstat_clr && !stall_hit) begin
					// Read clears the event; a new stall in that cycle wins
					st_next   = mls_pkg::mls_st_zwait;
					zcnt_next = zw_reg;
				end
			end
			mls_pkg::mls_st_zwait: begin
				if (stall_hit) begin
					st_next = mls_pkg::mls_st_halt;
				end else if (!stop_en_reg || zcnt_reg == '0) begin
					st_next = mls_pkg::mls_st_run;
				end else begin
					zcnt_next = zcnt_reg - 1'b1;
				end
			end
			default: begin
				st_next = mls_pkg::mls_st_run;
			end
		endcase
		// Ramp holds velocity at zero while stopped or waiting
		halt_next = (st_next != mls_pkg::mls_st_run);
		// Sticky events; set wins over the read-clear
		istat_next = istat_reg;
		if (rd_acc && hit(avs_address, `MLS_OFF_ISTAT)) begin
			istat_next = 2'h0;
		end
		if (st_reg != mls_pkg::mls_st_halt && st_next == mls_pkg::mls_st_halt) begin
			istat_next[`MLS_IRQ_STALL_BIT] = 1'b1;
		end
		if (ld.result_valid) begin
			istat_next[`MLS_IRQ_UPD_BIT] = 1'b1;
		end
		irq_next = |(istat_next & imask_next);
	end

	// Stall registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg     <= mls_pkg::mls_st_run;
			zcnt_reg   <= '0;
			halt_reg   <= 1'b0;
			vabove_reg <= 1'b0;
			istat_reg  <= 2'h0;
			irq_reg    <= 1'b0;
		end else begin
			st_reg     <= st_next;
			zcnt_reg   <= zcnt_next;
			halt_reg   <= halt_next;
			vabove_reg <= vabove_next;
			istat_reg  <= istat_next;
			irq_reg    <= irq_next;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign ramp_halt       = halt_reg;
	assign irq             = irq_reg;

endmodule

// File: rtl/mls_defs.svh
// Register offsets, field positions, reset values and counts of the load/stall block
`ifndef MLS_DEFS_SVH
`define MLS_DEFS_SVH

// ==========================================================
// Register byte offsets
`define MLS_OFF_SWMODE   8'h00
`define MLS_OFF_LOADCFG  8'h04
`define MLS_OFF_VLOW     8'h08
`define MLS_OFF_ZWAIT    8'h0C
`define MLS_OFF_RSTAT    8'h10
`define MLS_OFF_DSTAT    8'h14
`define MLS_OFF_ISTAT    8'h18
`define MLS_OFF_IMASK    8'h1C

// ==========================================================
// Field positions
`define MLS_SW_STOP_BIT    0
`define MLS_CFG_SGT_LSB    0
`define MLS_CFG_SGT_W      7
`define MLS_CFG_FILT_BIT   8
`define MLS_RSTAT_EVT_BIT  0
`define MLS_DSTAT_STALL_BIT 24
`define MLS_IRQ_STALL_BIT  0
`define MLS_IRQ_UPD_BIT    1
`define MLS_IRQ_W          2

// ==========================================================
// Reset values and counts
`define MLS_RST_SWMODE   1'b0
`define MLS_RST_SGT      7'h00
`define MLS_RST_FILT     1'b0
`define MLS_RST_IMASK    2'h0
`define MLS_SGT_SHIFT    4
`define MLS_FILT_LOG2    2
`define MLS_LOAD_MAX     10'h3FF

`endif

// File: rtl/mls_pkg.sv
// Types shared by the load/stall block
package mls_pkg;

	// ==========================================================
	// Load result word
	typedef logic [9:0] mls_load_t;

	// ==========================================================
	// Stall stop sequence, one-hot
	typedef enum logic [2:0] {
		mls_st_run   = 3'b001,
		mls_st_halt  = 3'b010,
		mls_st_zwait = 3'b100
	} mls_stall_state_t;

endpackage

// File: rtl/mls_load_if.sv
// Carrier between the stall controller and the load averaging filter
interface mls_load_if;
	mls_pkg::mls_load_t sample;        // Compensated per-step load
	logic               sample_valid;  // One pulse per full step
	logic               filt_en;       // Averaging over four steps
	mls_pkg::mls_load_t result;        // Reported load
	logic               result_valid;  // Pulse on each new result

	modport src (output sample, output sample_valid, output filt_en,
		input result, input result_valid);
	modport flt (input sample, input sample_valid, input filt_en,
		output result, output result_valid);
endinterface

// File: rtl/mls_load_filter.sv
// Load result filter: pass-through per full step or mean of four steps
`include "mls_defs.svh"
module mls_load_filter #(
	parameter int FILT_LOG2 = `MLS_FILT_LOG2
) (
	input  wire logic clk,
	input  wire logic nrst,
	mls_load_if.flt   ld
);

	// ==========================================================
	// Elaboration check
	if (FILT_LOG2 < 1 || FILT_LOG2 > 4) begin : g_bad_log2
		$error("mls_load_filter: FILT_LOG2 out of range");
	end

	// ==========================================================
	// State
	logic [FILT_LOG2-1:0]    cnt_reg, cnt_next;   // Samples taken in window
	logic [FILT_LOG2+9:0]    sum_reg, sum_next;   // Running sum
	mls_pkg::mls_load_t      res_reg, res_next;   // Held result
	logic                    vld_reg, vld_next;   // Result pulse
	logic [FILT_LOG2+9:0]    total;               // Sum with newest sample

	// Next-state for the averaging window
	always_comb begin
		total    = sum_reg + {{FILT_LOG2{1'b0}}, ld.sample};
		cnt_next = cnt_reg;
		sum_next = sum_reg;
		res_next = res_reg;
		vld_next = 1'b0;
		if (ld.sample_valid) begin
			if (!ld.filt_en) begin
				// Unfiltered: every full step updates
				res_next = ld.sample;
				vld_next = 1'b1;
				cnt_next = '0;
				sum_next = '0;
			end else if (cnt_reg == {FILT_LOG2{1'b1}}) begin
				// Filtered: one result per electrical period
				res_next = total[FILT_LOG2+9:FILT_LOG2];
				vld_next = 1'b1;
				cnt_next = '0;
				sum_next = '0;
			end else begin
				// Still filling the window
				sum_next = total;
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			sum_reg <= '0;
			res_reg <= `MLS_LOAD_MAX;
			vld_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			sum_reg <= sum_next;
			res_reg <= res_next;
			vld_reg <= vld_next;
		end
	end

	assign ld.result       = res_reg;
	assign ld.result_valid = vld_reg;

endmodule

// File: dv/mls_stall_sva.sv
// Port assertions for the load and stall controller
`include "mls_defs.svh"
// ====================
// Checker
module mls_stall_sva #(
	parameter int VEL_W = 24,  // Velocity width
	parameter int ZW_W  = 16   // Zero wait width
) (
	input wire logic             clk,
	input wire logic             nrst,
	input wire logic [7:0]       avs_address,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic [31:0]      avs_writedata,
	input wire logic [31:0]      avs_readdata,
	input wire logic             avs_waitrequest,
	input wire logic             fullstep_pulse,
	input wire logic [9:0]       raw_load,
	input wire logic [VEL_W-1:0] actual_velocity,
	input wire logic             ramp_halt,
	input wire logic             irq
);
	logic rel_reg;   // Release access seen while halted
	logic rel_next;  // Next release state
	logic ack_rel;   // Stop bit cleared or ramp status read
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// Only acked accesses count, a pending one cannot release
	assign ack_rel = !avs_waitrequest && ((avs_write && avs_address == `MLS_OFF_SWMODE
		&& !avs_writedata[0]) || (avs_read && avs_address == `MLS_OFF_RSTAT));
	// Forget releases while the ramp runs
	always_comb begin
		rel_next = ramp_halt ? (rel_reg || ack_rel) : ack_rel;
	end
	// Register release state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rel_reg <= 1'b0;
		end else begin
			rel_reg <= rel_next;
		end
	end
	// Request met by an idle slave
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// Driver status read being answered
	sequence s_dstat_ack;
		avs_read && !avs_waitrequest && avs_address == `MLS_OFF_DSTAT;
	endsequence
	a_req_answered: assert property (s_req |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
	a_halt_cause: assert property ($rose(ramp_halt) |-> $past(fullstep_pulse, 2))
		else $error("halt rose without a step two edges before");
	a_halt_speed: assert property ($rose(ramp_halt) |-> $past(actual_velocity, 2) != '0)
		else $error("halt rose at standstill");
	a_halt_holds: assert property ($rose(ramp_halt) |=> ramp_halt)
		else $error("halt lasted a single cycle");
	a_halt_release: assert property ($fell(ramp_halt) |-> rel_reg)
		else $error("halt dropped without a release access");
	a_result_range: assert property (s_dstat_ack |-> avs_readdata[23:10] == '0)
		else $error("load result wider than ten bits");
	a_flag_halt: assert property (s_dstat_ack |-> !avs_readdata[24] || ramp_halt)
		else $error("stall flag set while the ramp runs");
endmodule
bind mls_stall_top mls_stall_sva #(.VEL_W(VEL_W), .ZW_W(ZW_W)) mls_stall_sva_i (.clk, .nrst,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.fullstep_pulse, .raw_load, .actual_velocity, .ramp_halt, .irq);

// File: dv/mls_motor_model.sv
// Behavioural motor and power stage: steps, load samples, speed
module mls_motor_model #(
	parameter int VEL_W = 24  // Velocity width
) (
	input  wire logic        clk,
	input  wire logic        ramp_halt,
	output logic             fullstep_pulse,
	output logic [9:0]       raw_load,
	output logic [VEL_W-1:0] actual_velocity
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [VEL_W-1:0] vel_cmd;  // Speed the ramp would run at
	// ====================
	// Motion
	initial begin
		fullstep_pulse = 1'b0;
		raw_load = 10'h3FF;
		vel_cmd = '0;
	end
	// A halted ramp pins the speed to zero
	assign actual_velocity = ramp_halt ? '0 : vel_cmd;
	// New commanded speed
	task automatic set_speed(input logic [VEL_W-1:0] v);
		@(posedge clk);
		vel_cmd <= v;
	endtask
	// One full step; a stopped rotor gives none
	task automatic step(input logic [9:0] v);
		@(posedge clk);
		fullstep_pulse <= !ramp_halt;
		raw_load <= v;
		@(posedge clk);
		fullstep_pulse <= 1'b0;
		raw_load <= ~v; // Stale sample is not held
	endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the load and stall controller
`include "mls_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst;                   // Clock, reset active low
	logic [7:0]  avs_address;                 // Bus address
	logic        avs_read, avs_write;         // Bus strobes
	logic [31:0] avs_writedata, avs_readdata; // Bus data
	logic        avs_waitrequest;             // Bus stall
	logic        fullstep_pulse, ramp_halt;   // Step in, halt out
	logic [9:0]  raw_load;                    // Load sample
	logic [23:0] actual_velocity;             // Speed
	logic        irq;                         // Interrupt
	int          bad_count, n_compared;       // Counters
	int          thr, res, filt, cnt, k;      // Reference state
	int          last4[$];                    // Recent samples
	logic [31:0] rd;                          // Read word
	int          tv[5] = '{0, 63, -64, 7, -5};
	mls_stall_top mls_stall_top_i (.clk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .fullstep_pulse, .raw_load,
		.actual_velocity, .ramp_halt, .irq);
	mls_motor_model motor_i (.clk, .ramp_halt, .fullstep_pulse, .raw_load, .actual_velocity);
	always #20 clk = ~clk;
	// ====================
	// Checking and bus tasks
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic chk_pin(input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk_reg(e, rd);
	endtask
	// Reference: compensated, clamped load
	function automatic int comp(input int raw);
		int v;
		v = raw + thr * 16;
		return v < 0 ? 0 : (v > 1023 ? 1023 : v);
	endfunction
	task automatic stp(input int raw);
		last4.push_back(comp(raw));
		if (last4.size() > 4) void'(last4.pop_front());
		if (filt == 0) res = comp(raw);
		motor_i.step(raw[9:0]);
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
	// ====================
	// Main sequence
	initial begin
		{clk, nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{bad_count, n_compared, thr, res, filt} = '0;
		k = $urandom(32'hFD6FB2A7);
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		chk_pin(1'b0, ramp_halt);
		rchk(`MLS_OFF_DSTAT, 32'h3FF);
		rchk(`MLS_OFF_LOADCFG, 32'h0);
		rchk(8'h20, 32'h0);
		$display("test reset done");
		// Threshold table against extreme and random loads
		foreach (tv[i]) begin
			thr = tv[i];
			bus(1'b1, `MLS_OFF_LOADCFG, 32'(thr & 'h7F));
			for (k = 0; k < 3; k++) begin
				stp(k == 0 ? 0 : (k == 1 ? 1023 : $urandom % 1024));
				repeat (3) @(posedge clk);
				rchk(`MLS_OFF_DSTAT, 32'(res));
			end
		end
		$display("test threshold done");
		// Eight steps give two filtered results or eight plain ones
		thr = 0;
		for (int m = 1; m >= 0; m--) begin
			filt = m;
			bus(1'b1, `MLS_OFF_LOADCFG, 32'(m << 8));
			bus(1'b0, `MLS_OFF_ISTAT, 32'h0);
			cnt = 0;
			for (k = 0; k < 8; k++) begin
				stp($urandom % 1024);
				repeat (3) @(posedge clk);
				bus(1'b0, `MLS_OFF_ISTAT, 32'h0);
				cnt += rd[1];
				if (rd[1] && m == 1) res = last4.sum() >> 2;
				if (cnt >= 2 || m == 0) rchk(`MLS_OFF_DSTAT, 32'(res));
			end
			chk_reg(m ? 32'd2 : 32'd8, 32'(cnt));
		end
		$display("test filter done");
		// Stall below, then above, the speed limit
		bus(1'b1, `MLS_OFF_VLOW, 32'd100);
		bus(1'b1, `MLS_OFF_ZWAIT, 32'd5);
		bus(1'b1, `MLS_OFF_IMASK, 32'h1);
		bus(1'b1, `MLS_OFF_SWMODE, 32'h1);
		motor_i.set_speed(24'd50);
		repeat (3) @(posedge clk);
		stp(0);
		repeat (4) @(posedge clk);
		chk_pin(1'b0, ramp_halt);
		motor_i.set_speed(24'd500);
		repeat (3) @(posedge clk);
		stp(0);
		@(posedge clk);
		chk_pin(1'b0, ramp_halt);
		@(posedge clk);
		chk_pin(1'b1, ramp_halt);
		repeat (2) @(posedge clk);
		chk_pin(1'b1, irq);
		rchk(`MLS_OFF_DSTAT, 32'h0100_0000);
		rchk(`MLS_OFF_ISTAT, 32'h3);
		repeat (2) @(posedge clk);
		chk_pin(1'b0, irq);
		rchk(`MLS_OFF_RSTAT, 32'h1);
		for (k = 0; ramp_halt === 1'b1 && k < 20; k++) @(posedge clk);
		chk_reg(32'd7, 32'(k));
		rchk(`MLS_OFF_DSTAT, 32'h0);
		// Masked stall, released by clearing the stop bit
		bus(1'b1, `MLS_OFF_IMASK, 32'h0);
		// Reverse direction: magnitude of a negative speed must still qualify
		motor_i.set_speed(-24'd500);
		repeat (3) @(posedge clk);
		stp(0);
		repeat (4) @(posedge clk);
		chk_pin(1'b1, ramp_halt);
		chk_pin(1'b0, irq);
		bus(1'b1, `MLS_OFF_SWMODE, 32'h0);
		repeat (4) @(posedge clk);
		chk_pin(1'b0, ramp_halt);
		rchk(`MLS_OFF_ISTAT, 32'h3);
		$display("test stall done");
		tally_and_finish();
	end
endmodule
